//--- shared/pwm_steer_pkg.sv
// Purpose: Shared constants for blanking, fractional adjust and steering
// Assumes: 32-bit Avalon-MM register words, one byte used per register
// Notes:   Offsets are byte addresses
package pwm_steer_pkg;
    // ************
    // Register map
    // ************
    localparam logic [4:0] FFA_OFFSET    = 5'h00;
    localparam logic [4:0] BLKR_OFFSET   = 5'h04;
    localparam logic [4:0] BLKF_OFFSET   = 5'h08;
    localparam logic [4:0] STR0_OFFSET   = 5'h0C;
    localparam logic [4:0] STR1_OFFSET   = 5'h10;
    localparam logic [4:0] STATUS_OFFSET = 5'h14;

    // ************
    // Reset values and field layout
    // ************
    localparam logic [3:0] FFA_RESET   = 4'h0;
    localparam logic [7:0] BLKR_RESET  = 8'h00;
    localparam logic [7:0] BLKF_RESET  = 8'h00;
    localparam logic [5:0] STR0_RESET  = 6'h01;
    localparam logic [5:0] STR0_LOW_MASK = 6'h03;
    localparam int         SYNC_BIT    = 7;
    localparam int         LSMOD_BIT   = 1;
    localparam int         HSMOD_BIT   = 0;
    localparam int         FRAC_WIDTH  = 4;
    localparam int         BLANK_WIDTH = 8;

    // ************
    // Output modes
    // ************
    typedef enum logic [3:0] {
        MODE_SINGLE  = 4'h0,
        MODE_COMPL   = 4'h1,
        MODE_3PHASE  = 4'hC
    } output_mode_t;
endpackage

//--- rtl/frac_period_adjust.sv
// Purpose: Stretch period events by sixteenths of a clock on average
// Assumes: Period events are one-cycle pulses spaced two or more cycles
// Notes:   Output trails input by one cycle, two when a carry occurs
`timescale 1ns/1ps
module frac_period_adjust (
    input  wire logic                                sys_clk_in,
    input  wire logic                                reset_n_in,
    input  wire logic [pwm_steer_pkg::FRAC_WIDTH-1:0] frac_in,
    input  wire logic                                period_event_in,
    output logic                                     period_event_out
);
    import pwm_steer_pkg::*;

    logic [FRAC_WIDTH-1:0] acc_r;
    logic [FRAC_WIDTH:0]   sum_nxt;
    logic                  pending_r;

    // Carry out of the sixteenths accumulator adds one whole clock
    assign sum_nxt = {1'b0, acc_r} + {1'b0, frac_in}; // [RQ1]

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            acc_r <= '0;
        end else if (period_event_in) begin
            acc_r <= sum_nxt[FRAC_WIDTH-1:0];
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pending_r        <= 1'b0;
            period_event_out <= 1'b0;
        end else begin
            pending_r        <= period_event_in & sum_nxt[FRAC_WIDTH]; // [RQ1]
            period_event_out <= (period_event_in & ~sum_nxt[FRAC_WIDTH]) | pending_r;
        end
    end
endmodule // frac_period_adjust

//--- rtl/blank_timer.sv
// Purpose: Hold a blanking window for a programmed number of clocks
// Assumes: Trigger is a one-cycle edge pulse on the same clock
// Notes:   A count of zero gives no window; a new edge restarts it
`timescale 1ns/1ps
module blank_timer #(
    parameter int WIDTH = 8
) (
    input  wire logic             sys_clk_in,
    input  wire logic             reset_n_in,
    input  wire logic [WIDTH-1:0] length_in,
    input  wire logic             trigger_in,
    output logic                  blanking_out
);
    logic [WIDTH-1:0] count_r;

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            count_r <= '0;
        end else if (trigger_in) begin
            count_r <= length_in;
        end else if (count_r != '0) begin
            count_r <= count_r - 1'b1;
        end
    end

    assign blanking_out = (count_r != '0);
endmodule // blank_timer

//--- rtl/pwm_steer_top.sv
// Purpose: Fractional period adjust, edge blanking and six-pin steering
// Assumes: Time base, dead band and modulation source live outside
// Notes:
// Notes on behaviour
// [RQ1] Each period event is stretched by adjust value sixteenths of a clock.
// [RQ2] Upper four bits of fractional adjust read zero, writes ignored.
// [RQ3] Rising-edge blanking lasts the rising blank count of clocks.
// [RQ4] Falling-edge blanking lasts the falling blank count of clocks.
// [RQ5] Single-phase: set steering bit routes PWM to pin, clear holds inactive.
// [RQ6] Complementary: B, D, F carry complementary PWM when enabled.
// [RQ7] Single or complementary: A, C, E carry true PWM when enabled.
// [RQ8] Three-phase: bit F gives D,E high; bit E gives B,E high.
// [RQ9] Three-phase: bit D gives B,C high; bit C gives C,F high.
// [RQ10] Three-phase: bit B gives A,F high; bit A gives A,D high.
// [RQ11] Three-phase: clear steering bit applies no combination.
// [RQ12] Several bits set in three-phase: lowest-numbered bit wins.
// [RQ13] Second instance lacks steering bits C through F.
// [RQ14] Sync bit set: steering changes land at next period boundary.
// [RQ15] Low-side modulation gates B, D, F while high, low stays low.
// [RQ16] High-side modulation gates A, C, E while high, low stays low.
// [RQ17] Modulation enables off or outside three-phase leave steering as is.
// [RQ18] Synchronised writes wait in a holding register until period event.
//
// Decided for this implementation: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
module pwm_steer_top #(
    parameter bit SECOND_INSTANCE = 1'b0
) (
    input  wire logic        sys_clk_in,
    input  wire logic        reset_n_in,
    input  wire logic [4:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    input  wire logic [3:0]  avs_byteenable_in,
    output logic [31:0]      avs_readdata_out,
    output logic             avs_waitrequest_out,
    input  wire logic [3:0]  output_mode_sel_in,
    input  wire logic        period_event_in,
    input  wire logic        pwm_true_in,
    input  wire logic        pwm_compl_in,
    input  wire logic        modulation_in,
    output logic             period_event_out,
    output logic             rise_blank_out,
    output logic             fall_blank_out,
    output logic             out_a,
    output logic             out_b,
    output logic             out_c,
    output logic             out_d,
    output logic             out_e,
    output logic             out_f
);
    import pwm_steer_pkg::*;

    // ************
    // Register state
    // ************
    logic [FRAC_WIDTH-1:0]  fractional_period_adjust_r;
    logic [BLANK_WIDTH-1:0] rising_blank_time_r;
    logic [BLANK_WIDTH-1:0] falling_blank_time_r;
    logic [5:0]             steer_hold_r;
    logic [5:0]             steer_active_r;
    logic                   steer_update_on_period_r;
    logic                   low_side_mod_en_r;
    logic                   high_side_mod_en_r;

    // Bus handshake
    logic                   ack_r;
    logic                   req;
    logic                   wr_take;
    logic                   rd_take;

    // Data paths
    logic [5:0]             str0_wdata;
    logic [5:0]             impl_mask;
    logic [7:0]             rd_byte;

    // ************
    // Bus slave
    // ************
    // One wait state on every access keeps read data registered
    assign req                 = avs_read_in | avs_write_in;
    assign avs_waitrequest_out = req & ~ack_r;
    assign wr_take             = avs_write_in & ack_r & avs_byteenable_in[0];
    assign rd_take             = avs_read_in & ~ack_r;

    // Ack lasts one cycle only
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req & ~ack_r;
        end
    end

    // Bits C..F are absent on the second instance
    assign impl_mask  = SECOND_INSTANCE ? STR0_LOW_MASK : 6'h3F; // [RQ13]
    assign str0_wdata = avs_writedata_in[5:0] & impl_mask; // [RQ13]

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            fractional_period_adjust_r <= FFA_RESET;
        end else if (wr_take && avs_address_in == FFA_OFFSET) begin
            // Upper nibble dropped on write
            fractional_period_adjust_r <= avs_writedata_in[3:0]; // [RQ2]
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rising_blank_time_r <= BLKR_RESET;
        end else if (wr_take && avs_address_in == BLKR_OFFSET) begin
            rising_blank_time_r <= avs_writedata_in[7:0]; // [RQ3]
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            falling_blank_time_r <= BLKF_RESET;
        end else if (wr_take && avs_address_in == BLKF_OFFSET) begin
            falling_blank_time_r <= avs_writedata_in[7:0]; // [RQ4]
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            steer_update_on_period_r <= 1'b0;
        end else if (wr_take && avs_address_in == STR1_OFFSET) begin
            steer_update_on_period_r <= avs_writedata_in[SYNC_BIT]; // [RQ14]
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            low_side_mod_en_r  <= 1'b0;
            high_side_mod_en_r <= 1'b0;
        end else if (wr_take && avs_address_in == STR1_OFFSET) begin
            low_side_mod_en_r  <= avs_writedata_in[LSMOD_BIT];
            high_side_mod_en_r <= avs_writedata_in[HSMOD_BIT];
        end
    end

    // ************
    // Steering hold and active copies
    // ************
    // Readback shows the held copy
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            steer_hold_r <= STR0_RESET;
        end else if (wr_take && avs_address_in == STR0_OFFSET) begin
            steer_hold_r <= str0_wdata; // [RQ18]
        end
    end

    // Unsynchronised writes bypass the hold so the pins move at once
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            steer_active_r <= STR0_RESET;
        end else if (!steer_update_on_period_r) begin
            if (wr_take && avs_address_in == STR0_OFFSET) begin
                steer_active_r <= str0_wdata; // [RQ14]
            end else begin
                steer_active_r <= steer_hold_r; // [RQ14]
            end
        end else if (period_event_out) begin
            steer_active_r <= steer_hold_r; // [RQ14] [RQ18]
        end
    end

    // ************
    // Read mux
    // ************
    // Status shows live state
    always_comb begin
        rd_byte = 8'h00;
        unique case (avs_address_in)
            FFA_OFFSET:    rd_byte = {4'h0, fractional_period_adjust_r}; // [RQ2]
            BLKR_OFFSET:   rd_byte = rising_blank_time_r;
            BLKF_OFFSET:   rd_byte = falling_blank_time_r;
            STR0_OFFSET:   rd_byte = {2'b00, steer_hold_r};
            STR1_OFFSET:   rd_byte = {steer_update_on_period_r, 5'h00,
                                      low_side_mod_en_r, high_side_mod_en_r};
            STATUS_OFFSET: rd_byte = {fall_blank_out, rise_blank_out,
                                      steer_active_r};
            default:       rd_byte = 8'h00;
        endcase
    end

    // Held until the next read
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            avs_readdata_out <= 32'h0000_0000;
        end else if (rd_take) begin
            avs_readdata_out <= {24'h00_0000, rd_byte};
        end
    end

    // ************
    // Fractional period adjust
    // ************
    // Carries stretch by one clock
    frac_period_adjust u_frac (
        .sys_clk_in       (sys_clk_in),
        .reset_n_in       (reset_n_in),
        .frac_in          (fractional_period_adjust_r),
        .period_event_in  (period_event_in),
        .period_event_out (period_event_out)
    );

    // ************
    // Edge blanking
    // ************
    logic pwm_prev_r;
    logic edge_armed_r;
    logic pwm_rise;
    logic pwm_fall;

    // No false edge on the first clock after reset
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pwm_prev_r   <= 1'b0;
            edge_armed_r <= 1'b0;
        end else begin
            pwm_prev_r   <= pwm_true_in;
            edge_armed_r <= 1'b1;
        end
    end

    assign pwm_rise = edge_armed_r & pwm_true_in & ~pwm_prev_r;
    assign pwm_fall = edge_armed_r & ~pwm_true_in & pwm_prev_r;

    // Zero count gives no window

    blank_timer #(
        .WIDTH (BLANK_WIDTH)
    ) u_blank_rise (
        .sys_clk_in   (sys_clk_in),
        .reset_n_in   (reset_n_in),
        .length_in    (rising_blank_time_r), // [RQ3]
        .trigger_in   (pwm_rise),
        .blanking_out (rise_blank_out)
    );

    blank_timer #(
        .WIDTH (BLANK_WIDTH)
    ) u_blank_fall (
        .sys_clk_in   (sys_clk_in),
        .reset_n_in   (reset_n_in),
        .length_in    (falling_blank_time_r), // [RQ4]
        .trigger_in   (pwm_fall),
        .blanking_out (fall_blank_out)
    );

    // ************
    // Three-phase combination, order is F E D C B A
    // ************
    function automatic logic [5:0] phase_combo(input logic [5:0] steer);
        logic [5:0] combo;
        combo = 6'h00;
        // Lowest set bit wins, so test from A upward
        if (steer[0]) begin
            combo = 6'b001001; // [RQ10] [RQ12]
        end else if (steer[1]) begin
            combo = 6'b100001; // [RQ10] [RQ12]
        end else if (steer[2]) begin
            combo = 6'b100100; // [RQ9] [RQ12]
        end else if (steer[3]) begin
            combo = 6'b000110; // [RQ9] [RQ12]
        end else if (steer[4]) begin
            combo = 6'b010010; // [RQ8] [RQ12]
        end else if (steer[5]) begin
            combo = 6'b011000; // [RQ8] [RQ12]
        end
        return combo; // [RQ11]
    endfunction

    // ************
    // Output steering
    // ************
    logic [5:0] pins_nxt;
    logic [5:0] combo;
    logic [5:0] mod_gate;

    // Active copy, never the held one
    assign combo = phase_combo(steer_active_r);

    // High side is A, C, E; low side is B, D, F
    always_comb begin
        mod_gate = 6'h3F;
        if (high_side_mod_en_r) begin
            mod_gate[0] = modulation_in; // [RQ16]
            mod_gate[2] = modulation_in; // [RQ16]
            mod_gate[4] = modulation_in; // [RQ16]
        end

        if (low_side_mod_en_r) begin
            mod_gate[1] = modulation_in; // [RQ15]
            mod_gate[3] = modulation_in; // [RQ15]
            mod_gate[5] = modulation_in; // [RQ15]
        end
    end

    // Unlisted modes park all pins low; other patterns belong elsewhere
    always_comb begin
        pins_nxt = 6'h00;
        case (output_mode_sel_in)
            MODE_SINGLE: begin
                pins_nxt = steer_active_r & {6{pwm_true_in}}; // [RQ5] [RQ7]
            end

            MODE_COMPL: begin
                pins_nxt[0] = steer_active_r[0] & pwm_true_in;  // [RQ7]
                pins_nxt[2] = steer_active_r[2] & pwm_true_in;  // [RQ7]
                pins_nxt[4] = steer_active_r[4] & pwm_true_in;  // [RQ7]
                pins_nxt[1] = steer_active_r[1] & pwm_compl_in; // [RQ6]
                pins_nxt[3] = steer_active_r[3] & pwm_compl_in; // [RQ6]
                pins_nxt[5] = steer_active_r[5] & pwm_compl_in; // [RQ6]
            end

            MODE_3PHASE: begin
                // Gate only ever lowers a pin, so low stays unmodulated
                pins_nxt = combo & mod_gate; // [RQ15] [RQ16] [RQ17]
            end

            default: begin
                pins_nxt = 6'h00; // [RQ17]
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            // Registered pins never glitch
            out_a <= 1'b0;
            out_b <= 1'b0;
            out_c <= 1'b0;
            out_d <= 1'b0;
            out_e <= 1'b0;
            out_f <= 1'b0;
        end else begin
            out_a <= pins_nxt[0];
            out_b <= pins_nxt[1];
            out_c <= pins_nxt[2];
            out_d <= pins_nxt[3];
            out_e <= pins_nxt[4];
            out_f <= pins_nxt[5];
        end
    end
endmodule // pwm_steer_top

//--- verification/switch_driver_model.sv
// Purpose: Six-pin power switch driver seen from the steering outputs
// Assumes: Gate inputs registered on sys_clk_in; armed only in bridge use
// Notes:   Sticky flag when both switches of one leg would conduct
`timescale 1ns/1ps
module switch_driver_model (
    input  wire logic       sys_clk_in,
    input  wire logic       reset_n_in,
    input  wire logic       arm_in,
    input  wire logic [5:0] gate_in,
    output logic            shoot_seen_out
);
    logic arm_r;
    // Arm lags one clock, as the pins lag the mode input
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            arm_r          <= 1'b0;
            shoot_seen_out <= 1'b0;
        end else begin
            arm_r <= arm_in;
            if (arm_r && arm_in && |(gate_in[4:0] & gate_in[5:1] & 5'h15)) begin
                shoot_seen_out <= 1'b1;
            end
        end
    end
endmodule // switch_driver_model

//--- verification/pwm_steer_chk.sv
// Purpose: Port-level checks on bus timing, steering, blanking and periods
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Pins are registered, so they are judged against past inputs
`timescale 1ns/1ps
module pwm_steer_chk (
    input wire logic       sys_clk_in,
    input wire logic       reset_n_in,
    input wire logic       avs_read_in,
    input wire logic       avs_write_in,
    input wire logic       avs_waitrequest_out,
    input wire logic [3:0] output_mode_sel_in,
    input wire logic       period_event_in,
    input wire logic       pwm_true_in,
    input wire logic       pwm_compl_in,
    input wire logic       period_event_out,
    input wire logic       rise_blank_out,
    input wire logic       fall_blank_out,
    input wire logic       out_a,
    input wire logic       out_b,
    input wire logic       out_c,
    input wire logic       out_d,
    input wire logic       out_e,
    input wire logic       out_f
);
    logic [5:0] pins;
    assign pins = {out_f, out_e, out_d, out_c, out_b, out_a};
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);

    a_wait_single: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
        |=> !avs_waitrequest_out) else $error("long wait");
    a_single_route: assert property ($past(output_mode_sel_in) == 4'h0 |->
        (pins & ~{6{$past(pwm_true_in)}}) == 6'h00) else $error("single pin");
    a_compl_route: assert property ($past(output_mode_sel_in) == 4'h1 |->
        ((pins & 6'h2A) == 6'h00 || $past(pwm_compl_in)) &&
        ((pins & 6'h15) == 6'h00 || $past(pwm_true_in))) else $error("compl pin wrong");
    a_three_legs: assert property ($past(output_mode_sel_in) == 4'hC |->
        $onehot0(pins & 6'h15) && $onehot0(pins & 6'h2A) &&
        (pins[4:0] & pins[5:1] & 5'h15) == 5'h00) else $error("illegal phase pair");
    a_unlisted_low: assert property (!($past(output_mode_sel_in) inside {4'h0, 4'h1, 4'hC})
        |-> pins == 6'h00) else $error("unlisted mode pins");
    a_period_bound: assert property (period_event_in |-> ##[1:2] period_event_out)
        else $error("period event lost");
    a_period_cause: assert property (period_event_out |->
        $past(period_event_in) || $past(period_event_in, 2)) else $error("spurious period");
    a_rise_cause: assert property ($rose(rise_blank_out) |->
        $past(pwm_true_in) && !$past(pwm_true_in, 2)) else $error("rise blank uncaused");
    a_fall_cause: assert property ($rose(fall_blank_out) |->
        !$past(pwm_true_in) && $past(pwm_true_in, 2)) else $error("fall blank uncaused");

    c_period: cover property (period_event_in ##2 period_event_out);
    c_blank: cover property ($rose(rise_blank_out));
    c_phase: cover property (output_mode_sel_in == 4'hC && pins != 6'h00);
endmodule // pwm_steer_chk

bind pwm_steer_top pwm_steer_chk u_chk (.sys_clk_in, .reset_n_in, .avs_read_in,
    .avs_write_in, .avs_waitrequest_out, .output_mode_sel_in, .period_event_in,
    .pwm_true_in, .pwm_compl_in, .period_event_out, .rise_blank_out,
    .fall_blank_out, .out_a, .out_b, .out_c, .out_d, .out_e, .out_f);

//--- verification/pwm_blanking_and_output_steering_bench.sv
// Purpose: Self-checking bench for steering, blanking and period adjust
// Assumes: One-wait Avalon slave; pins follow inputs after one clock
// Notes:   Table of steering cases first, hand-written cases after
`timescale 1ns/1ps
module pwm_blanking_and_output_steering_bench;
    import pwm_steer_pkg::*;
    typedef struct packed {
        logic [3:0] mode;
        logic [5:0] steer;
        logic       pt;
        logic       pc;
        logic [5:0] pins;
    } row_t;
    logic        sys_clk_in = 1'b0, reset_n_in = 1'b0;
    logic [4:0]  avs_address_in = 5'h00;
    logic        avs_read_in = 1'b0, avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out;
    logic [3:0]  avs_byteenable_in = 4'hF, output_mode_sel_in = 4'h0;
    logic        period_event_in = 1'b0, modulation_in = 1'b0;
    logic        pwm_true_in = 1'b0, pwm_compl_in = 1'b0;
    logic        avs_waitrequest_out, period_event_out, rise_blank_out, fall_blank_out;
    logic        out_a, out_b, out_c, out_d, out_e, out_f, shoot_seen;
    logic [5:0]  pins;
    logic [31:0] rd;
    int          err_total = 0, total_checks = 0, lat, l, n;
    // ************
    // Steering table: mode, steer bits, true, compl, expected pins
    // ************
    row_t rows [15] = '{
        '{4'h0, 6'h3F, 1'b1, 1'b0, 6'h3F}, '{4'h0, 6'h15, 1'b1, 1'b0, 6'h15},
        '{4'h0, 6'h3F, 1'b0, 1'b1, 6'h00}, '{4'h1, 6'h3F, 1'b1, 1'b0, 6'h15},
        '{4'h1, 6'h3F, 1'b0, 1'b1, 6'h2A}, '{4'hC, 6'h20, 1'b0, 1'b0, 6'h18},
        '{4'hC, 6'h10, 1'b0, 1'b0, 6'h12}, '{4'hC, 6'h08, 1'b0, 1'b0, 6'h06},
        '{4'hC, 6'h04, 1'b0, 1'b0, 6'h24}, '{4'hC, 6'h02, 1'b0, 1'b0, 6'h21},
        '{4'hC, 6'h01, 1'b0, 1'b0, 6'h09}, '{4'hC, 6'h00, 1'b0, 1'b0, 6'h00},
        '{4'hC, 6'h0C, 1'b0, 1'b0, 6'h24}, '{4'hC, 6'h3F, 1'b0, 1'b0, 6'h09},
        '{4'h2, 6'h3F, 1'b1, 1'b1, 6'h00}};
    logic [7:0] rst_exp [7] = '{{4'h0, FFA_RESET}, BLKR_RESET, BLKF_RESET,
        {2'b00, STR0_RESET}, 8'h00, {2'b00, STR0_RESET}, 8'h00};

    assign pins = {out_f, out_e, out_d, out_c, out_b, out_a};
    always #5 sys_clk_in = ~sys_clk_in;

    pwm_steer_top dut (.sys_clk_in, .reset_n_in, .avs_address_in, .avs_read_in,
        .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out,
        .avs_waitrequest_out, .output_mode_sel_in, .period_event_in, .pwm_true_in,
        .pwm_compl_in, .modulation_in, .period_event_out, .rise_blank_out,
        .fall_blank_out, .out_a, .out_b, .out_c, .out_d, .out_e, .out_f);
    switch_driver_model partner (.sys_clk_in, .reset_n_in,
        .arm_in(output_mode_sel_in == 4'hC), .gate_in(pins), .shoot_seen_out(shoot_seen));

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic bus_op(input logic w, input logic [4:0] a, input logic [7:0] d,
                          output logic [31:0] q);
        @(posedge sys_clk_in);
        avs_address_in   <= a;
        avs_writedata_in <= {24'h0, d};
        avs_write_in     <= w;
        avs_read_in      <= !w;
        do @(posedge sys_clk_in); while (avs_waitrequest_out !== 1'b0);
        q = avs_readdata_out;
        avs_write_in <= 1'b0;
        avs_read_in  <= 1'b0;
    endtask
    task automatic settle();
        repeat (3) @(posedge sys_clk_in);
        @(negedge sys_clk_in);
    endtask
    task automatic period_pulse(output int c);
        @(posedge sys_clk_in);
        period_event_in <= 1'b1;
        @(posedge sys_clk_in);
        period_event_in <= 1'b0;
        c = 0;
        do begin
            @(negedge sys_clk_in);
            c++;
        end while (period_event_out !== 1'b1 && c < 8);
    endtask
    task automatic blank_count(input logic lvl, output int c);
        @(posedge sys_clk_in);
        pwm_true_in <= lvl;
        c = 0;
        repeat (20) begin
            @(negedge sys_clk_in);
            if ((lvl ? rise_blank_out : fall_blank_out) === 1'b1) c++;
        end
    endtask
    task automatic mod_case(input logic [3:0] m, input logic [7:0] s1, input logic md,
                            input logic [5:0] exp);
        bus_op(1'b1, STR1_OFFSET, s1, rd);
        output_mode_sel_in <= m;
        modulation_in      <= md;
        settle();
        check("modulated pins", {26'h0, exp}, {26'h0, pins});
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge sys_clk_in);
        reset_n_in <= 1'b1;
        foreach (rows[i]) begin
            bus_op(1'b1, STR0_OFFSET, {2'b00, rows[i].steer}, rd);
            output_mode_sel_in <= rows[i].mode;
            pwm_true_in        <= rows[i].pt;
            pwm_compl_in       <= rows[i].pc;
            settle();
            check("steered pins", {26'h0, rows[i].pins}, {26'h0, pins});
        end
        $display("test steering table done");
        // ************
        // Second reset, then register defaults and odd accesses
        // ************
        @(posedge sys_clk_in);
        reset_n_in <= 1'b0;
        repeat (10) @(posedge sys_clk_in);
        reset_n_in <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            bus_op(1'b0, 5'(i * 4), 8'h00, rd);
            check("reset value", {24'h0, rst_exp[i]}, rd);
        end
        bus_op(1'b1, FFA_OFFSET, 8'hFF, rd);
        bus_op(1'b0, FFA_OFFSET, 8'h00, rd);
        check("adjust upper bits", 32'h0F, rd);
        bus_op(1'b1, 5'h18, 8'hAA, rd);
        bus_op(1'b0, 5'h18, 8'h00, rd);
        check("unmapped read", 32'h0, rd);
        $display("test registers done");
        // Eight sixteenths over sixteen events: eight extra clocks
        bus_op(1'b1, FFA_OFFSET, 8'h08, rd);
        lat = 0;
        repeat (16) begin
            period_pulse(l);
            lat += l;
        end
        check("period latency sum", 32'd24, 32'(lat));
        bus_op(1'b1, FFA_OFFSET, 8'h00, rd);
        $display("test fractional adjust done");
        bus_op(1'b1, STR0_OFFSET, 8'h01, rd);
        output_mode_sel_in <= 4'h0;
        pwm_true_in        <= 1'b1;
        bus_op(1'b1, STR1_OFFSET, 8'h80, rd);
        bus_op(1'b1, STR0_OFFSET, 8'h02, rd);
        settle();
        check("pins before boundary", 32'h01, {26'h0, pins});
        bus_op(1'b0, STR0_OFFSET, 8'h00, rd);
        check("held steering", 32'h02, rd);
        period_pulse(l);
        settle();
        check("pins after boundary", 32'h02, {26'h0, pins});
        bus_op(1'b1, STR1_OFFSET, 8'h00, rd);
        bus_op(1'b1, STR0_OFFSET, 8'h01, rd);
        $display("test sync steering done");
        mod_case(4'hC, 8'h03, 1'b0, 6'h00);
        mod_case(4'hC, 8'h03, 1'b1, 6'h09);
        mod_case(4'hC, 8'h01, 1'b0, 6'h08);
        mod_case(4'hC, 8'h02, 1'b0, 6'h01);
        mod_case(4'h0, 8'h03, 1'b0, 6'h01);
        check("leg overlap", 32'h0, {31'h0, shoot_seen});
        $display("test modulation done");
        blank_count(1'b0, n);
        bus_op(1'b1, BLKR_OFFSET, 8'h05, rd);
        bus_op(1'b1, BLKF_OFFSET, 8'h03, rd);
        blank_count(1'b1, n);
        check("rise blank cycles", 32'd5, 32'(n));
        blank_count(1'b0, n);
        check("fall blank cycles", 32'd3, 32'(n));
        $display("test blanking done");
        final_report();
    end

    initial begin
        #200us;
        err_total++;
        final_report();
    end
endmodule // pwm_blanking_and_output_steering_bench
